// >>> src/at2_timer.v
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "at2_defines.vh"

module at2_timer
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // timer oscillator pin and oscillator control
  input wire osc_input_pin,
  output reg osc_enable,
  output reg ext_clk_buf_enable,
  // cpu side interrupt interface
  input wire global_irq_enable,
  input wire compare_vector_ack,
  input wire overflow_vector_ack,
  output wire compare_irq_req,
  output wire overflow_irq_req
);

  reg ext_clock_enable_q;
  reg async_select_q;
  reg counter_update_busy_q;
  reg compare_update_busy_q;
  reg control_update_busy_q;
  reg [7:0] count_value_q;
  reg [7:0] count_temp_q;
  reg [7:0] compare_value_q;
  reg [7:0] compare_temp_q;
  reg [6:0] timer_control_q;
  reg [6:0] control_temp_q;
  reg [1:0] irq_mask_q;
  reg compare_flag_q;
  reg overflow_flag_q;
  reg timer_sync_mode_q;
  reg prescaler_reset_q;
  reg [`AT2_PRESCALE_WIDTH-1:0] prescale_q;
  reg count_down_q;
  reg match_block_q;
  reg osc_meta_q;
  reg osc_sync_q;
  reg osc_prev_q;

  wire apb_wr;
  wire apb_rd_ok;
  wire addr_ok;
  wire wr_status;
  wire wr_count;
  wire wr_compare;
  wire wr_control;
  wire wr_mask;
  wire wr_flags;
  wire wr_general;
  wire osc_tick;
  wire src_tick;
  wire [1:0] wave_mode;
  wire [2:0] clk_sel;
  wire [7:0] count_top;
  wire count_match;
  wire pwm_phase;
  reg count_tick;
  reg [7:0] count_d;
  reg count_down_d;
  reg overflow_event;

  assign addr_ok = (paddr == `AT2_ADDR_ASYNC_CLOCK_STATUS) ||
                   (paddr == `AT2_ADDR_COUNT_VALUE) ||
                   (paddr == `AT2_ADDR_COMPARE_VALUE) ||
                   (paddr == `AT2_ADDR_TIMER_CONTROL) ||
                   (paddr == `AT2_ADDR_TIMER2_IRQ_MASK) ||
                   (paddr == `AT2_ADDR_TIMER2_IRQ_FLAGS) ||
                   (paddr == `AT2_ADDR_GENERAL_TIMER_CONTROL);
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign apb_wr = psel & penable & pwrite & addr_ok;
  assign apb_rd_ok = psel & ~penable & ~pwrite & addr_ok;
  assign wr_status = apb_wr & (paddr == `AT2_ADDR_ASYNC_CLOCK_STATUS);
  assign wr_count = apb_wr & (paddr == `AT2_ADDR_COUNT_VALUE);
  assign wr_compare = apb_wr & (paddr == `AT2_ADDR_COMPARE_VALUE);
  assign wr_control = apb_wr & (paddr == `AT2_ADDR_TIMER_CONTROL);
  assign wr_mask = apb_wr & (paddr == `AT2_ADDR_TIMER2_IRQ_MASK);
  assign wr_flags = apb_wr & (paddr == `AT2_ADDR_TIMER2_IRQ_FLAGS);
  assign wr_general = apb_wr &
                      (paddr == `AT2_ADDR_GENERAL_TIMER_CONTROL);

  // osc pin is slow against core_clk; edge taken after two flops
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      osc_meta_q <= osc_input_pin;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end
  assign osc_tick = osc_sync_q & ~osc_prev_q;

  assign src_tick = async_select_q ? osc_tick : 1'b1;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_enable <= 1'b1;
      ext_clk_buf_enable <= 1'b0;
    end
    else
    begin
      osc_enable <= ~ext_clock_enable_q;
      ext_clk_buf_enable <= ext_clock_enable_q & async_select_q;
    end
  end

  // prescaler; the counter tick is a one-cycle enable
  assign clk_sel = timer_control_q[`AT2_CLK_SEL_MSB:0];
  always @*
  begin
    case (clk_sel)
      3'h1: count_tick = src_tick;
      3'h2: count_tick = src_tick & (&prescale_q[2:0]);
      3'h3: count_tick = src_tick & (&prescale_q[4:0]);
      3'h4: count_tick = src_tick & (&prescale_q[5:0]);
      3'h5: count_tick = src_tick & (&prescale_q[6:0]);
      3'h6: count_tick = src_tick & (&prescale_q[7:0]);
      3'h7: count_tick = src_tick & (&prescale_q[9:0]);
      default: count_tick = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prescale_q <= {`AT2_PRESCALE_WIDTH{1'b0}};
    // reset held while the bit stands
    else if (prescaler_reset_q)
      prescale_q <= {`AT2_PRESCALE_WIDTH{1'b0}};
    else if (src_tick)
      prescale_q <= prescale_q + 1'b1;
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prescaler_reset_q <= 1'b0;
      timer_sync_mode_q <= 1'b0;
    end
    else if (wr_general)
    begin
      prescaler_reset_q <= pwdata[`AT2_BIT_PRESCALER_RESET] |
                           prescaler_reset_q;
      timer_sync_mode_q <= pwdata[`AT2_BIT_TIMER_SYNC_MODE];
    end
    else if (prescaler_reset_q & ~timer_sync_mode_q & src_tick)
      prescaler_reset_q <= 1'b0;
  end

  // counting sequence
  assign wave_mode = {timer_control_q[`AT2_BIT_WAVE_MODE1],
                      timer_control_q[`AT2_BIT_WAVE_MODE0]};
  assign pwm_phase = (wave_mode == 2'b01);
  assign count_top = (wave_mode == 2'b10) ? compare_value_q :
                     `AT2_COUNT_MAX;
  // match blocked after a counter load
  assign count_match = (count_value_q == compare_value_q) &
                       ~match_block_q;

  always @*
  begin
    count_d = count_value_q + 8'h01;
    count_down_d = count_down_q;
    overflow_event = 1'b0;
    if (pwm_phase)
    begin
      if (!count_down_q)
      begin
        if (count_value_q == `AT2_COUNT_MAX)
        begin
          count_down_d = 1'b1;
          count_d = count_value_q - 8'h01;
        end
      end
      else if (count_value_q == `AT2_COUNT_BOTTOM)
      begin
        count_down_d = 1'b0;
        overflow_event = 1'b1;
      end
      else
        count_d = count_value_q - 8'h01;
    end
    else
    begin
      if (count_value_q == `AT2_COUNT_MAX)
        overflow_event = 1'b1;
      if (count_value_q == count_top)
        count_d = `AT2_COUNT_BOTTOM;
    end
  end

  // counter and temporary transfers
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_value_q <= `AT2_RESET_BYTE;
      count_down_q <= 1'b0;
      match_block_q <= 1'b0;
      compare_value_q <= `AT2_RESET_BYTE;
      timer_control_q <= 7'h00;
      counter_update_busy_q <= 1'b0;
      compare_update_busy_q <= 1'b0;
      control_update_busy_q <= 1'b0;
    end
    else
    begin
      if (count_tick)
      begin
        count_value_q <= count_d;
        count_down_q <= count_down_d;
        match_block_q <= 1'b0;
      end
      // counter load on the timer edge in async mode
      if (wr_count & ~async_select_q)
      begin
        count_value_q <= pwdata[7:0];
        match_block_q <= 1'b1;
      end
      else if (counter_update_busy_q & src_tick)
      begin
        count_value_q <= count_temp_q;
        match_block_q <= 1'b1;
        counter_update_busy_q <= 1'b0;
      end
      if (wr_count & async_select_q)
        counter_update_busy_q <= 1'b1;
      if (wr_compare & ~async_select_q)
        compare_value_q <= pwdata[7:0];
      else if (compare_update_busy_q & src_tick)
      begin
        compare_value_q <= compare_temp_q;
        compare_update_busy_q <= 1'b0;
      end
      if (wr_compare & async_select_q)
        compare_update_busy_q <= 1'b1;
      if (wr_control & ~async_select_q)
        timer_control_q <= pwdata[6:0];
      else if (control_update_busy_q & src_tick)
      begin
        timer_control_q <= control_temp_q;
        control_update_busy_q <= 1'b0;
      end
      if (wr_control & async_select_q)
        control_update_busy_q <= 1'b1;
    end
  end

  // temporary holding registers; a busy write overwrites them
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_temp_q <= `AT2_RESET_BYTE;
      compare_temp_q <= `AT2_RESET_BYTE;
      control_temp_q <= 7'h00;
    end
    else
    begin
      if (wr_count)
        count_temp_q <= pwdata[7:0];
      if (wr_compare)
        compare_temp_q <= pwdata[7:0];
      if (wr_control)
        control_temp_q <= pwdata[6:0];
    end
  end

  // switching source preserves nothing extra; software rewrites
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_clock_enable_q <= 1'b0;
      async_select_q <= 1'b0;
      irq_mask_q <= 2'b00;
    end
    else
    begin
      if (wr_status)
      begin
        ext_clock_enable_q <= pwdata[`AT2_BIT_EXT_CLOCK_ENABLE];
        async_select_q <= pwdata[`AT2_BIT_ASYNC_SELECT];
      end
      if (wr_mask)
        irq_mask_q <= pwdata[1:0];
    end
  end

  // interrupt flags; a set in the same cycle beats a clear
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      compare_flag_q <= 1'b0;
      overflow_flag_q <= 1'b0;
    end
    else
    begin
      if (count_tick & count_match)
        compare_flag_q <= 1'b1;
      else if (compare_vector_ack |
               (wr_flags & pwdata[`AT2_BIT_COMPARE]))
        compare_flag_q <= 1'b0;
      if (count_tick & overflow_event)
        overflow_flag_q <= 1'b1;
      else if (overflow_vector_ack |
               (wr_flags & pwdata[`AT2_BIT_OVERFLOW]))
        overflow_flag_q <= 1'b0;
    end
  end

  assign compare_irq_req = irq_mask_q[`AT2_BIT_COMPARE] &
                           global_irq_enable & compare_flag_q;
  assign overflow_irq_req = irq_mask_q[`AT2_BIT_OVERFLOW] &
                            global_irq_enable & overflow_flag_q;

  // read data registered in setup, valid in the access phase
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (apb_rd_ok)
    begin
      case (paddr)
        `AT2_ADDR_ASYNC_CLOCK_STATUS:
          prdata <= {27'h0, ext_clock_enable_q, async_select_q,
                     counter_update_busy_q, compare_update_busy_q,
                     control_update_busy_q};
        // live counter, temporary compare and control
        `AT2_ADDR_COUNT_VALUE:
          prdata <= {24'h0, count_value_q};
        `AT2_ADDR_COMPARE_VALUE:
          prdata <= {24'h0, compare_temp_q};
        `AT2_ADDR_TIMER_CONTROL:
          prdata <= {25'h0, control_temp_q};
        `AT2_ADDR_TIMER2_IRQ_MASK:
          prdata <= {30'h0, irq_mask_q};
        `AT2_ADDR_TIMER2_IRQ_FLAGS:
          prdata <= {30'h0, compare_flag_q, overflow_flag_q};
        `AT2_ADDR_GENERAL_TIMER_CONTROL:
          prdata <= {24'h0, timer_sync_mode_q, 5'h00,
                     prescaler_reset_q, 1'b0};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> src/at2_defines.vh
`ifndef AT2_DEFINES_VH
`define AT2_DEFINES_VH

// register byte addresses
`define AT2_ADDR_ASYNC_CLOCK_STATUS 8'h00
`define AT2_ADDR_COUNT_VALUE 8'h04
`define AT2_ADDR_COMPARE_VALUE 8'h08
`define AT2_ADDR_TIMER_CONTROL 8'h0C
`define AT2_ADDR_TIMER2_IRQ_MASK 8'h10
`define AT2_ADDR_TIMER2_IRQ_FLAGS 8'h14
`define AT2_ADDR_GENERAL_TIMER_CONTROL 8'h18

// async_clock_status fields
`define AT2_BIT_EXT_CLOCK_ENABLE 4
`define AT2_BIT_ASYNC_SELECT 3
`define AT2_BIT_COUNTER_UPDATE_BUSY 2
`define AT2_BIT_COMPARE_UPDATE_BUSY 1
`define AT2_BIT_CONTROL_UPDATE_BUSY 0

// timer_control fields
`define AT2_BIT_FORCE_COMPARE 7
`define AT2_BIT_WAVE_MODE0 6
`define AT2_BIT_WAVE_MODE1 3
`define AT2_CLK_SEL_MSB 2

// mask and flag fields
`define AT2_BIT_COMPARE 1
`define AT2_BIT_OVERFLOW 0

// general_timer_control fields
`define AT2_BIT_TIMER_SYNC_MODE 7
`define AT2_BIT_PRESCALER_RESET 1

// reset values, counter limits and prescaler width
`define AT2_RESET_BYTE 8'h00
`define AT2_COUNT_MAX 8'hFF
`define AT2_COUNT_BOTTOM 8'h00
`define AT2_PRESCALE_WIDTH 10

`endif

// >>> bench/at2_timer_chk.sv
`timescale 1ns/1ps
`include "at2_defines.vh"

module at2_timer_chk
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // oscillator
  input wire osc_input_pin,
  input wire osc_enable,
  input wire ext_clk_buf_enable,
  // interrupts
  input wire global_irq_enable,
  input wire compare_vector_ack,
  input wire overflow_vector_ack,
  input wire compare_irq_req,
  input wire overflow_irq_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  wire bad_addr;
  assign bad_addr = (paddr > `AT2_ADDR_GENERAL_TIMER_CONTROL) ||
    (paddr[1:0] != 2'h0);

  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_st_wr;
    psel && penable && pwrite && paddr == `AT2_ADDR_ASYNC_CLOCK_STATUS;
  endsequence

  property p_ready;
    s_acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_err;
    s_acc and bad_addr |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_err_only;
    pslverr |-> s_acc and bad_addr;
  endproperty
  a_err_only: assert property (p_err_only) else $error("stray error");
  property p_err_hold;
    pslverr && !pwrite |-> $stable(prdata);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("read data moved");
  property p_hi0;
    s_acc and !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  property p_osc;
    s_st_wr |-> ##2 osc_enable == !$past(pwdata[4], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_buf;
    s_st_wr |-> ##2 ext_clk_buf_enable == ($past(pwdata[4], 2) &&
      $past(pwdata[3], 2));
  endproperty
  a_buf: assert property (p_buf) else $error("input buffer wrong");
  property p_cmp;
    compare_irq_req |-> global_irq_enable;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare req ungated");
  property p_ovf;
    overflow_irq_req |-> global_irq_enable;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow req ungated");
endmodule

// >>> bench/at2_timer_tb.sv
`timescale 1ns/1ps
`include "at2_defines.vh"

module at2_timer_tb;
  reg core_clk;
  reg rst;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg osc_input_pin;
  reg global_irq_enable;
  reg compare_vector_ack;
  reg overflow_vector_ack;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire osc_enable;
  wire ext_clk_buf_enable;
  wire compare_irq_req;
  wire overflow_irq_req;
  integer miscompares;
  integer samples_checked;
  integer cyc;
  integer seed;
  integer i;
  integer n;
  reg [7:0] r;
  reg [7:0] v;
  reg [7:0] c1;
  reg [7:0] a;
  reg slv_err;

  at2_timer dut_u
  (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .osc_input_pin(osc_input_pin),
    .osc_enable(osc_enable),
    .ext_clk_buf_enable(ext_clk_buf_enable),
    .global_irq_enable(global_irq_enable),
    .compare_vector_ack(compare_vector_ack),
    .overflow_vector_ack(overflow_vector_ack),
    .compare_irq_req(compare_irq_req),
    .overflow_irq_req(overflow_irq_req)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function [7:0] busy_exp(input integer k);
    busy_exp = 8'h18 | (8'h04 >> k);
  endfunction

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk(input [7:0] s, input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e)
      begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask

  // setup then access, held until pready is seen high
  task apb(input [7:0] ad, input w, input [7:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
        @(posedge core_clk);
      r = prdata[7:0];
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // slow enough that the pin synchroniser sees every edge
  task osc_tick;
    begin
      @(posedge core_clk);
      osc_input_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      osc_input_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask

  task wait_req(input s);
    begin
      n = 0;
      while ((s ? compare_irq_req : overflow_irq_req) !== 1'b1 && n < 600)
      begin
        @(posedge core_clk);
        n = n + 1;
      end
    end
  endtask

  task ack(input s);
    begin
      @(posedge core_clk);
      compare_vector_ack <= s;
      overflow_vector_ack <= !s;
      @(posedge core_clk);
      compare_vector_ack <= 1'b0;
      overflow_vector_ack <= 1'b0;
      @(negedge core_clk);
    end
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end

  initial
  begin
    seed = 65047;
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    osc_input_pin = 1'b0;
    global_irq_enable = 1'b0;
    compare_vector_ack = 1'b0;
    overflow_vector_ack = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    apb(`AT2_ADDR_ASYNC_CLOCK_STATUS, 1'b0, 8'h00);
    chk(r, 8'h00);
    chk(osc_enable, 8'h01);
    chk(slv_err, 8'h00);
    chk(ext_clk_buf_enable, 8'h00);
    v = $random(seed);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h00);
    apb(`AT2_ADDR_COUNT_VALUE, 1'b1, v);
    apb(`AT2_ADDR_COUNT_VALUE, 1'b0, 8'h00);
    chk(r, v);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h01);
    apb(`AT2_ADDR_COUNT_VALUE, 1'b0, 8'h00);
    c1 = r;
    apb(`AT2_ADDR_COUNT_VALUE, 1'b0, 8'h00);
    chk(r == c1, 8'h00);
    global_irq_enable <= 1'b1;
    apb(`AT2_ADDR_TIMER2_IRQ_MASK, 1'b1, 8'h03);
    apb(`AT2_ADDR_TIMER2_IRQ_MASK, 1'b0, 8'h00);
    chk(r, 8'h03);
    v = 8'h10 + ($random(seed) & 8'h7F);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h00);
    // drop flags left over from the free run above
    apb(`AT2_ADDR_TIMER2_IRQ_FLAGS, 1'b1, 8'h03);
    apb(`AT2_ADDR_COUNT_VALUE, 1'b1, v - 8'h10);
    apb(`AT2_ADDR_COMPARE_VALUE, 1'b1, v);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h01);
    wait_req(1'b1);
    chk(compare_irq_req, 8'h01);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h00);
    apb(`AT2_ADDR_COMPARE_VALUE, 1'b1, 8'h00);
    apb(`AT2_ADDR_TIMER2_IRQ_FLAGS, 1'b0, 8'h00);
    chk(r & 8'h02, 8'h02);
    apb(`AT2_ADDR_TIMER2_IRQ_FLAGS, 1'b1, 8'h02);
    apb(`AT2_ADDR_TIMER2_IRQ_FLAGS, 1'b0, 8'h00);
    chk(r & 8'h02, 8'h00);
    apb(`AT2_ADDR_COUNT_VALUE, 1'b1, 8'hF0);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h01);
    wait_req(1'b0);
    chk(overflow_irq_req, 8'h01);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h00);
    global_irq_enable <= 1'b0;
    @(negedge core_clk);
    chk(overflow_irq_req, 8'h00);
    @(posedge core_clk);
    global_irq_enable <= 1'b1;
    @(negedge core_clk);
    chk(overflow_irq_req, 8'h01);
    ack(1'b0);
    chk(overflow_irq_req, 8'h00);
    chk(compare_irq_req, 8'h01);
    ack(1'b1);
    chk(compare_irq_req, 8'h00);
    apb(`AT2_ADDR_ASYNC_CLOCK_STATUS, 1'b1, 8'h10);
    apb(`AT2_ADDR_ASYNC_CLOCK_STATUS, 1'b1, 8'h18);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(osc_enable, 8'h00);
    chk(ext_clk_buf_enable, 8'h01);
    for (i = 0; i < 3; i = i + 1)
    begin
      v = $random(seed);
      if (i == 2)
        v = v & 8'h48;
      a = `AT2_ADDR_COUNT_VALUE + 8'h04 * i;
      apb(a, 1'b1, v);
      apb(`AT2_ADDR_ASYNC_CLOCK_STATUS, 1'b0, 8'h00);
      chk(r, busy_exp(i));
      if (i > 0)
      begin
        apb(a, 1'b0, 8'h00);
        chk(r, v);
      end
      osc_tick;
      apb(`AT2_ADDR_ASYNC_CLOCK_STATUS, 1'b0, 8'h00);
      chk(r, 8'h18);
      apb(a, 1'b0, 8'h00);
      chk(r, v);
    end
    apb(8'h1C, 1'b1, 8'hFF);
    chk(slv_err, 8'h01);
    apb(8'h1C, 1'b0, 8'h00);
    chk(r, v);
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b1, 8'h02);
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b0, 8'h00);
    chk(r, 8'h02);
    osc_tick;
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b0, 8'h00);
    chk(r, 8'h00);
    apb(`AT2_ADDR_ASYNC_CLOCK_STATUS, 1'b1, 8'h00);
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b1, 8'h82);
    repeat (3) @(posedge core_clk);
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b0, 8'h00);
    chk(r, 8'h82);
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b1, 8'h02);
    apb(`AT2_ADDR_GENERAL_TIMER_CONTROL, 1'b0, 8'h00);
    chk(r, 8'h00);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h40);
    apb(`AT2_ADDR_COUNT_VALUE, 1'b1, 8'hF0);
    apb(`AT2_ADDR_TIMER2_IRQ_FLAGS, 1'b1, 8'h03);
    apb(`AT2_ADDR_TIMER_CONTROL, 1'b1, 8'h41);
    repeat (40) @(posedge core_clk);
    apb(`AT2_ADDR_TIMER2_IRQ_FLAGS, 1'b0, 8'h00);
    chk(r & 8'h01, 8'h00);
    wait_req(1'b0);
    chk(overflow_irq_req, 8'h01);
    finish_test;
  end
endmodule

bind at2_timer at2_timer_chk chk_u
(
  .core_clk(core_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .prdata(prdata),
  .pslverr(pslverr),
  .osc_input_pin(osc_input_pin),
  .osc_enable(osc_enable),
  .ext_clk_buf_enable(ext_clk_buf_enable),
  .global_irq_enable(global_irq_enable),
  .compare_vector_ack(compare_vector_ack),
  .overflow_vector_ack(overflow_vector_ack),
  .compare_irq_req(compare_irq_req),
  .overflow_irq_req(overflow_irq_req)
);
